// *** hw/dcd_device.sv ***
/*
  Device end: samples command pins each rising edge, decodes commands,
  tracks bank and power state from clock-enable history and masks write data.
  Assumes the pins arrive from logic on the same clock, so no synchroniser.
*/
// Operation
// - Decode only from sampled strobes and CKE.
// - Mode register write loads address opcode.
// - Bank address selects target bank.
// - WE selects write/read; A10 auto precharge.
// - Bursts of four always complete.
// - Controller limits power-down time; dcd_ctrl stays down for as long as pd_in is held.
// - Termination ignored; unavailable in self refresh.
// - Self refresh exits asynchronously on CKE.
// - Only NOP/deselect at power-down edges.
// - Power-down type depends on open rows.
// - Self refresh only from all idle.
// - Exit interval NOP only; read after 200.
// - No power-down during busy operations.
// - CKE holds level three clocks.
// - CKE high during calibration.
// - Termination input defined in power-down.
// - Controller avoids illegal combinations; dcd_ctrl sends refresh at a CKE fall even with rows open.
// - Power state from previous/current CKE.
// - Only defined commands while CKE high.
// - Mask high suppresses write beat.
// - NOP and deselect never end bursts.
`default_nettype none
module dcd_device
(
  input  wire logic                          clk_in,       // 40 MHz clock.
  input  wire logic                          arst_n_in,    // Asynchronous reset.
  dcd_if.dev                                 pins,         // Command pins.
  output logic [dcd_pkg::NUM_BANKS-1:0]      bank_open_out, // Banks with an open row.
  output dcd_pkg::dcd_state_t                state_out,    // Power state.
  output dcd_pkg::dcd_cmd_t                  cmd_out,      // Last decoded command.
  output logic                               cmd_vld_out,  // Pulse per command.
  output logic [dcd_pkg::BANK_W-1:0]         bank_out,     // Target bank.
  output logic [dcd_pkg::ADDR_W-1:0]         addr_out,     // Captured address.
  output logic [dcd_pkg::BANK_W-1:0]         mrs_sel_out,  // Mode register chosen.
  output logic [dcd_pkg::ADDR_W-1:0]         mrs_op_out,   // Mode register opcode.
  output logic                               mrs_vld_out,  // Pulse on register load.
  output logic                               burst_out,    // Burst under way.
  output logic                               wr_beat_out,  // Pulse per stored beat.
  output logic [dcd_pkg::DATA_W-1:0]         wr_data_out,  // Stored beat data.
  output logic                               odt_on_out,   // Termination active.
  output logic                               illegal_out   // Pulse on illegal input.
);
  logic                            cke_prev;     // CKE at the previous edge.
  dcd_pkg::dcd_state_t             state;        // Current power state.
  dcd_pkg::dcd_cmd_t               cmd;          // Combinational decode.
  logic                            nop_like;     // NOP or deselect.
  logic [1:0]                      beats;        // Beats remaining minus one.
  logic                            bursting;     // Burst in progress.
  logic                            burst_wr;     // Burst is a write.
  logic                            bad;          // Illegal combination this edge.
  logic [dcd_pkg::NUM_BANKS-1:0]   open_banks;   // Open row per bank.

  // Decode uses only the strobes and A10; CKE gates it separately.
  always_comb
  begin
    cmd = dcd_pkg::DCD_CMD_NOP;
    if (pins.cs_n)
      cmd = dcd_pkg::DCD_CMD_DESEL;
    else
    begin
      unique case ({pins.ras_n, pins.cas_n, pins.we_n})
        3'h0: cmd = dcd_pkg::DCD_CMD_MRS;
        3'h1: cmd = dcd_pkg::DCD_CMD_REF;
        3'h2: cmd = pins.addr[dcd_pkg::AP_BIT] ? dcd_pkg::DCD_CMD_PREA
                                               : dcd_pkg::DCD_CMD_PRE;
        3'h3: cmd = dcd_pkg::DCD_CMD_ACT;
        // WE low is write, high is read; A10 chooses auto precharge.
        3'h4: cmd = pins.addr[dcd_pkg::AP_BIT] ? dcd_pkg::DCD_CMD_WRA
                                               : dcd_pkg::DCD_CMD_WR;
        3'h5: cmd = pins.addr[dcd_pkg::AP_BIT] ? dcd_pkg::DCD_CMD_RDA
                                               : dcd_pkg::DCD_CMD_RD;
        3'h6: cmd = dcd_pkg::DCD_CMD_NOP;
        3'h7: cmd = dcd_pkg::DCD_CMD_NOP;
      endcase
    end
  end

  // NOP and deselect are legal at a CKE rise, and at a fall with no burst running; refresh with all banks idle is also legal at such a fall.
  assign nop_like = (cmd == dcd_pkg::DCD_CMD_NOP) || (cmd == dcd_pkg::DCD_CMD_DESEL);

  // Legality check over state, CKE history and command.
  always_comb
  begin
    bad = 1'b0;
    if (cke_prev && !pins.cke)
      bad = !(nop_like || (cmd == dcd_pkg::DCD_CMD_REF && open_banks == '0)) || bursting;
    else if (!cke_prev && pins.cke)
      bad = !nop_like;
    else if (cke_prev && pins.cke && bursting)
      // A new column command would cut a burst of four short.
      bad = (cmd == dcd_pkg::DCD_CMD_RD) || (cmd == dcd_pkg::DCD_CMD_RDA) ||
            (cmd == dcd_pkg::DCD_CMD_WR) || (cmd == dcd_pkg::DCD_CMD_WRA);
  end

  // Previous CKE level, kept for every transition decision.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      cke_prev <= 1'b0;
    else
      cke_prev <= pins.cke;
  end

  // Power state machine; termination level never enters it.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      state <= dcd_pkg::DCD_ST_IDLE;
    else if (cke_prev && !pins.cke && !bad)
    begin
      if (cmd == dcd_pkg::DCD_CMD_REF)
        state <= dcd_pkg::DCD_ST_SREF;
      else
        state <= (open_banks != '0) ? dcd_pkg::DCD_ST_APD
                                    : dcd_pkg::DCD_ST_PPD;
    end
    else if (!cke_prev && pins.cke)
      // Exit from any low-power state back to bank state.
      state <= (open_banks != '0) ? dcd_pkg::DCD_ST_ACTIVE : dcd_pkg::DCD_ST_IDLE;
    else if (cke_prev && pins.cke)
      state <= (open_banks != '0) ? dcd_pkg::DCD_ST_ACTIVE : dcd_pkg::DCD_ST_IDLE;
  end

  // Open-row tracking per bank chosen by the bank address.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      open_banks <= '0;
    else if (cke_prev && pins.cke)
    begin
      unique case (cmd)
        dcd_pkg::DCD_CMD_ACT:  open_banks[pins.ba] <= 1'b1;
        dcd_pkg::DCD_CMD_PRE:  open_banks[pins.ba] <= 1'b0;
        dcd_pkg::DCD_CMD_PREA: open_banks <= '0;
        dcd_pkg::DCD_CMD_WRA, dcd_pkg::DCD_CMD_RDA:
          if (!bad)
            open_banks[pins.ba] <= 1'b0;
        default: open_banks <= open_banks;
      endcase
    end
  end

  // Burst counter; NOP and deselect leave it running.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      beats    <= 2'h0;
      bursting <= 1'b0;
      burst_wr <= 1'b0;
    end
    else if (cke_prev && pins.cke && !bursting &&
             (cmd == dcd_pkg::DCD_CMD_WR || cmd == dcd_pkg::DCD_CMD_WRA ||
              cmd == dcd_pkg::DCD_CMD_RD || cmd == dcd_pkg::DCD_CMD_RDA))
    begin
      beats    <= 2'(dcd_pkg::BURST_LEN - 1);
      bursting <= 1'b1;
      burst_wr <= (cmd == dcd_pkg::DCD_CMD_WR) || (cmd == dcd_pkg::DCD_CMD_WRA);
    end
    else if (bursting)
    begin
      beats    <= beats - 2'h1;
      bursting <= (beats != 2'h0);
    end
  end

  // Command and mode register capture.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      cmd_out     <= dcd_pkg::DCD_CMD_NOP;
      cmd_vld_out <= 1'b0;
      bank_out    <= '0;
      addr_out    <= '0;
      mrs_sel_out <= '0;
      mrs_op_out  <= '0;
      mrs_vld_out <= 1'b0;
      illegal_out <= 1'b0;
    end
    else
    begin
      cmd_vld_out <= cke_prev && pins.cke && !bad;
      mrs_vld_out <= cke_prev && pins.cke && (cmd == dcd_pkg::DCD_CMD_MRS);
      illegal_out <= bad;
      if (cke_prev && pins.cke)
      begin
        cmd_out  <= cmd;
        bank_out <= pins.ba;
        addr_out <= pins.addr;
      end
      if (cke_prev && pins.cke && cmd == dcd_pkg::DCD_CMD_MRS)
      begin
        mrs_sel_out <= pins.ba;
        mrs_op_out  <= pins.addr;
      end
    end
  end

  // Write beats stored only with mask low, sampled with the data.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      wr_beat_out <= 1'b0;
      wr_data_out <= '0;
    end
    else
    begin
      wr_beat_out <= bursting && burst_wr && !pins.dm;
      if (bursting && burst_wr && !pins.dm)
        wr_data_out <= pins.wdata;
    end
  end

  // Self refresh ends the moment CKE rises, without a clock edge.
  // Termination is cut while in self refresh.
  assign state_out     = (state == dcd_pkg::DCD_ST_SREF && pins.cke) ?
                         dcd_pkg::DCD_ST_IDLE : state;
  assign odt_on_out    = pins.odt && (state_out != dcd_pkg::DCD_ST_SREF);
  assign bank_open_out = open_banks;
  assign burst_out     = bursting;
endmodule
`default_nettype wire

// *** shared/dcd_pkg.sv ***
/*
  Shared definitions for the command decoder and clock-enable state logic:
  bus widths, command codes, power states and timing counts.
  Assumes both ends run from the same 40 MHz clock.
*/
`default_nettype none
package dcd_pkg;
  localparam int BANK_W       = 3;    // Bank address width.
  localparam int ADDR_W       = 16;   // Row/column address width.
  localparam int NUM_BANKS    = 8;    // Number of banks.
  localparam int AP_BIT       = 10;   // Address bit that requests auto precharge.
  localparam int BURST_LEN    = 4;    // Beats per burst.
  localparam int CKE_MIN_CLKS = 3;    // Least run of equal clock-enable levels.
  localparam int SRX_RD_CLKS  = 200;  // Clocks after self refresh exit before a read.
  localparam int DATA_W       = 8;    // Write data width.

  // Decoded command codes.
  typedef enum logic [3:0] {
    DCD_CMD_NOP, DCD_CMD_DESEL, DCD_CMD_MRS, DCD_CMD_REF, DCD_CMD_PRE,
    DCD_CMD_PREA, DCD_CMD_ACT, DCD_CMD_WR, DCD_CMD_WRA, DCD_CMD_RD, DCD_CMD_RDA
  } dcd_cmd_t;

  // Power states of the device.
  typedef enum logic [2:0] {
    DCD_ST_IDLE, DCD_ST_ACTIVE, DCD_ST_PPD, DCD_ST_APD, DCD_ST_SREF
  } dcd_state_t;
endpackage
`default_nettype wire

// *** shared/dcd_if.sv ***
/*
  Command and data pins between controller and device.
  Assumes both ends share one clock; the testbench connects the modports.
*/
`default_nettype none
interface dcd_if;
  logic                          cke;      // Clock enable.
  logic                          cs_n;     // Chip select, active low.
  logic                          ras_n;    // Row strobe, active low.
  logic                          cas_n;    // Column strobe, active low.
  logic                          we_n;     // Write enable, active low.
  logic [dcd_pkg::BANK_W-1:0]    ba;       // Bank address.
  logic [dcd_pkg::ADDR_W-1:0]    addr;     // Address.
  logic                          odt;      // Termination control.
  logic [dcd_pkg::DATA_W-1:0]    wdata;    // Write data beat.
  logic                          dm;       // Data mask, high suppresses the beat.
  modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt, wdata, dm);
  modport dev  (input  cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt, wdata, dm);
endinterface
`default_nettype wire

// *** hw/dcd_ctrl.sv ***
/*
  Controller end: turns user requests into legal pin sequences.
  Assumes one user request at a time, held until accepted by ready.
*/
`default_nettype none
module dcd_ctrl
(
  input  wire logic                          clk_in,     // 40 MHz clock.
  input  wire logic                          arst_n_in,  // Asynchronous reset.
  dcd_if.ctrl                                pins,       // Command pins.
  input  wire logic                          req_in,     // Request valid.
  input  wire dcd_pkg::dcd_cmd_t             cmd_in,     // Requested command.
  input  wire logic [dcd_pkg::BANK_W-1:0]    ba_in,      // Bank.
  input  wire logic [dcd_pkg::ADDR_W-1:0]    addr_in,    // Address.
  input  wire logic                          pd_in,      // Want power-down (level).
  input  wire logic                          sref_in,    // Want self refresh (level).
  input  wire logic                          odt_in,     // Termination request.
  input  wire logic [dcd_pkg::DATA_W-1:0]    wdata_in,   // Write data.
  input  wire logic                          dm_in,      // Write mask.
  output logic                               ready_out   // Request accepted.
);
  logic [7:0] hold;   // Clocks left on a CKE level or exit interval.
  logic [2:0] busy;   // Clocks left after any issued command other than activate.
  logic       low;    // CKE currently low.
  logic       go;     // Issue a user command now.
  logic       enter;  // Drop CKE now.
  logic       leave;  // Raise CKE now.

  // Issue only in steady CKE-high with no hold pending.
  assign go    = req_in && !low && hold == 8'h00 && busy == 3'h0 && !pd_in && !sref_in;
  // No low-power entry while an operation runs.
  assign enter = !low && (pd_in || sref_in) && hold == 8'h00 && busy == 3'h0;
  assign leave = low && !pd_in && !sref_in && hold == 8'h00;
  assign ready_out = go;

  // CKE level and the least-time holds after each change.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      low  <= 1'b0;
      hold <= 8'h00;
    end
    else if (enter)
    begin
      low  <= 1'b1;
      hold <= 8'(dcd_pkg::CKE_MIN_CLKS - 1);
    end
    else if (leave)
    begin
      low  <= 1'b0;
      hold <= 8'(dcd_pkg::SRX_RD_CLKS);
    end
    else if (hold != 8'h00)
      hold <= hold - 8'h01;
  end

  // Busy count covers a burst of four after every issued command except activate.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      busy <= 3'h0;
    else if (go && cmd_in != dcd_pkg::DCD_CMD_ACT)
      busy <= 3'(dcd_pkg::BURST_LEN);
    else if (busy != 3'h0)
      busy <= busy - 3'h1;
  end

  // Pin drive; NOP everywhere else, refresh at self refresh entry.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      pins.cke <= 1'b0;
      {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= 4'hf;
      pins.ba <= '0;
      pins.addr <= '0;
      pins.odt <= 1'b0;
      pins.wdata <= '0;
      pins.dm <= 1'b1;
    end
    else
    begin
      // High unless low power is wanted, so calibration never sees it drop.
      pins.cke <= enter ? 1'b0 : (leave ? 1'b1 : !low);
      pins.odt <= odt_in && !(low && sref_in);  // Defined level always.
      pins.wdata <= wdata_in;
      pins.dm <= dm_in;
      pins.ba <= ba_in;
      pins.addr <= addr_in;
      if (enter && sref_in)
        {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= 4'h1;
      else if (go)
      begin
        unique case (cmd_in)
          dcd_pkg::DCD_CMD_MRS: {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= 4'h0;
          dcd_pkg::DCD_CMD_REF: {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= 4'h1;
          dcd_pkg::DCD_CMD_PRE, dcd_pkg::DCD_CMD_PREA:
            {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= 4'h2;
          dcd_pkg::DCD_CMD_ACT: {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= 4'h3;
          dcd_pkg::DCD_CMD_WR, dcd_pkg::DCD_CMD_WRA:
            {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= 4'h4;
          dcd_pkg::DCD_CMD_RD, dcd_pkg::DCD_CMD_RDA:
            {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= 4'h5;
          default: {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= 4'h7;
        endcase
      end
      else
        {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= 4'h7;
    end
  end
endmodule
`default_nettype wire

// *** test/dcd_properties.sv ***
/*
  Concurrent checks on the pins and device outputs of the joined pair.
  Assumes the testbench instantiates it beside the shared interface.
*/
`default_nettype none
module dcd_properties
(
  input wire logic                          clk_in,
  input wire logic                          arst_n_in,
  input wire logic                          cke,
  input wire logic                          cs_n,
  input wire logic                          ras_n,
  input wire logic                          cas_n,
  input wire logic                          we_n,
  input wire logic [dcd_pkg::BANK_W-1:0]    ba,
  input wire logic [dcd_pkg::ADDR_W-1:0]    addr,
  input wire logic                          dm,
  input wire logic [dcd_pkg::NUM_BANKS-1:0] bank_open_out,
  input wire dcd_pkg::dcd_state_t           state_out,
  input wire dcd_pkg::dcd_cmd_t             cmd_out,
  input wire logic                          cmd_vld_out,
  input wire logic                          mrs_vld_out,
  input wire logic                          burst_out,
  input wire logic                          wr_beat_out,
  input wire logic                          odt_on_out,
  input wire logic                          illegal_out
);
  logic cke_q;  // Clock enable seen at the previous edge.
  // Keeps the enable history that every power transition depends on.
  always_ff @(posedge clk_in or negedge arst_n_in)
    if (!arst_n_in)
      cke_q <= 1'b0;
    else
      cke_q <= cke;
  wire logic on = cke & cke_q & ~cs_n;  // Command taken with a steady high enable.
  wire logic nop = cs_n | (ras_n & cas_n & we_n);  // No operation or deselect.
  wire logic open = |bank_open_out;  // Some bank holds a row.
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  a_write_decode: assert property (on && ras_n && !cas_n && !we_n && !addr[10]
    |=> cmd_vld_out && cmd_out == dcd_pkg::DCD_CMD_WR) else $error("write not decoded");
  a_read_autopre: assert property (on && ras_n && !cas_n && we_n && addr[10]
    |=> cmd_out == dcd_pkg::DCD_CMD_RDA && !bank_open_out[$past(ba)]) else $error("read ap");
  a_act_opens: assert property (on && !ras_n && cas_n && we_n
    |=> bank_open_out[$past(ba)]) else $error("bank not opened");
  a_mode_load: assert property (on && !ras_n && !cas_n && !we_n |=> mrs_vld_out)
    else $error("mode load missed");
  a_burst_len: assert property ($rose(burst_out) |-> burst_out [*4] ##1 !burst_out)
    else $error("burst length wrong");
  a_mask_beat: assert property (wr_beat_out |-> $past(burst_out) && !$past(dm))
    else $error("masked beat stored");
  a_pd_kind: assert property (cke_q && !cke && nop |=> state_out ==
    ($past(open) ? dcd_pkg::DCD_ST_APD : dcd_pkg::DCD_ST_PPD)) else $error("power-down kind");
  a_sref_entry: assert property (cke_q && !cke && !cs_n && !ras_n && !cas_n && we_n
    && !open |=> state_out == dcd_pkg::DCD_ST_SREF) else $error("self refresh not entered");
  a_sref_exit: assert property (!(cke && state_out == dcd_pkg::DCD_ST_SREF))
    else $error("self refresh kept with enable high");
  a_low_hold: assert property (!cke && !cke_q && state_out inside
    {dcd_pkg::DCD_ST_PPD, dcd_pkg::DCD_ST_APD} |=> $stable(state_out)) else $error("pd left");
  a_cke_run: assert property ($changed(cke) |=> $stable(cke) [*2])
    else $error("enable run short");
  a_odt_sref: assert property (state_out == dcd_pkg::DCD_ST_SREF |-> !odt_on_out)
    else $error("termination in self refresh");
  a_no_illegal: assert property (!illegal_out)
    else $error("controller sent illegal input");
  // The main scenarios that the bench is meant to reach.
  c_beat: cover property (wr_beat_out);
  c_apd: cover property (state_out == dcd_pkg::DCD_ST_APD);
  c_sref: cover property (state_out == dcd_pkg::DCD_ST_SREF);
endmodule
`default_nettype wire

// *** test/ddr2_command_cke_decoder_test.sv ***
/*
  Bench: a controller and device pair driven from the user side, and a lone
  device whose pins the bench drives. Assumes package and interface first.
*/
`default_nettype none
module ddr2_command_cke_decoder_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0;  // The 40 MHz clock.
  logic arst_n_in = 1'b0;  // Reset, held low at start.
  logic req_in = 1'b0, pd_in = 1'b0, sref_in = 1'b0, odt_in = 1'b0, dm_in = 1'b1;
  dcd_pkg::dcd_cmd_t cmd_in = dcd_pkg::DCD_CMD_NOP;  // User command.
  logic [dcd_pkg::BANK_W-1:0] ba_in = 3'h0, bank_out, mrs_sel_out;
  logic [dcd_pkg::ADDR_W-1:0] addr_in = 16'h0000, mrs_op_out, addr_out;
  logic [dcd_pkg::DATA_W-1:0] wdata_in = 8'h00, wr_data_out;
  logic [dcd_pkg::NUM_BANKS-1:0] bank_open_out;
  logic ready_out, cmd_vld_out, mrs_vld_out, burst_out, wr_beat_out, odt_on_out, illegal_out;
  logic b_vld, b_ill;  // Lone device pulses.
  dcd_pkg::dcd_cmd_t cmd_out, b_cmd, got_cmd;
  dcd_pkg::dcd_state_t state_out;
  logic [2:0] got_bank;  // Bank of the last real command.
  logic [15:0] got_addr;  // Address of the last real command.
  logic [7:0] beats [$];  // Stored write beats, in order.
  int miscompares = 0, samples_checked = 0;
  dcd_if lnk();
  dcd_if bad();
  // The clock toggles every half period.
  always #12.5 clk_in = ~clk_in;
  dcd_ctrl dcd_ctrl_i(.clk_in, .arst_n_in, .pins(lnk.ctrl), .req_in, .cmd_in, .ba_in,
    .addr_in, .pd_in, .sref_in, .odt_in, .wdata_in, .dm_in, .ready_out);
  dcd_device dcd_device_i(.clk_in, .arst_n_in, .pins(lnk.dev), .bank_open_out, .state_out,
    .cmd_out, .cmd_vld_out, .bank_out, .addr_out, .mrs_sel_out, .mrs_op_out, .mrs_vld_out,
    .burst_out, .wr_beat_out, .wr_data_out, .odt_on_out, .illegal_out);
  dcd_device dcd_device_i2(.clk_in, .arst_n_in, .pins(bad.dev), .bank_open_out(),
    .state_out(), .cmd_out(b_cmd), .cmd_vld_out(b_vld), .bank_out(), .addr_out(),
    .mrs_sel_out(), .mrs_op_out(), .mrs_vld_out(), .burst_out(), .wr_beat_out(),
    .wr_data_out(), .odt_on_out(), .illegal_out(b_ill));
  dcd_properties dcd_properties_i(.clk_in, .arst_n_in, .cke(lnk.cke), .cs_n(lnk.cs_n),
    .ras_n(lnk.ras_n), .cas_n(lnk.cas_n), .we_n(lnk.we_n), .ba(lnk.ba), .addr(lnk.addr),
    .dm(lnk.dm), .bank_open_out, .state_out, .cmd_out, .cmd_vld_out, .mrs_vld_out,
    .burst_out, .wr_beat_out, .odt_on_out, .illegal_out);
  // Records decoded commands and stored beats; idle codes are skipped.
  always @(negedge clk_in)
  begin
    if (cmd_vld_out === 1'b1 && cmd_out > dcd_pkg::DCD_CMD_DESEL)
    begin
      got_cmd = cmd_out;
      got_bank = bank_out;
      got_addr = addr_out;
    end
    if (wr_beat_out === 1'b1)
      beats.push_back(wr_data_out);
  end
  task automatic finish_test();
    if (miscompares == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Drives the lone device: enable, {cs,ras,cas,we,a10} and bank.
  task automatic bdrv(input logic k, input logic [4:0] c, input logic [2:0] b);
    bad.cke <= k;
    {bad.cs_n, bad.ras_n, bad.cas_n, bad.we_n} <= c[4:1];
    bad.addr <= {5'h00, c[0], 10'h000};
    bad.ba <= b;
  endtask
  // Holds a request until taken, then feeds four beats with mask m.
  task automatic req(input dcd_pkg::dcd_cmd_t c, input logic [2:0] b,
                     input logic [15:0] a, input logic [3:0] m);
    int n;
    @(posedge clk_in);
    req_in <= 1'b1;
    cmd_in <= c;
    ba_in <= b;
    addr_in <= a;
    for (n = 0; n < 400 && ready_out !== 1'b1; n++)
      @(negedge clk_in);
    if (n == 400)
      chk(16'h0bad, 16'h0000);
    if (n == 400)
      finish_test();
    for (n = 0; n < 5; n++)
    begin
      @(posedge clk_in);
      req_in <= 1'b0;
      wdata_in <= 8'h10 + n[7:0];
      dm_in <= (n < 4) ? m[n] : 1'b1;
    end
    // Returns on a falling edge so that callers read settled outputs.
    repeat (6) @(negedge clk_in);
    chk(got_cmd, c);
  endtask
  // Bounded wait for a power state; a timeout ends the run.
  task automatic wait_state(input dcd_pkg::dcd_state_t s);
    int n;
    for (n = 0; n < 400 && state_out !== s; n++)
      @(negedge clk_in);
    chk(state_out, s);
    if (n == 400)
      finish_test();
    // Leaves on a rising edge, where the next input change belongs.
    @(posedge clk_in);
  endtask
  task automatic expect_ill();
    logic seen = 1'b0;
    repeat (4)
    begin
      @(negedge clk_in);
      seen |= (b_ill === 1'b1);
    end
    chk(seen, 1'b1);
  endtask
  task automatic t_decode_table();
    logic [4:0] pat [9] = '{5'h00, 5'h02, 5'h06, 5'h08, 5'h09, 5'h0a, 5'h0b, 5'h04, 5'h05};
    dcd_pkg::dcd_cmd_t e [9] = '{dcd_pkg::DCD_CMD_MRS, dcd_pkg::DCD_CMD_REF,
      dcd_pkg::DCD_CMD_ACT, dcd_pkg::DCD_CMD_WR, dcd_pkg::DCD_CMD_WRA, dcd_pkg::DCD_CMD_RD,
      dcd_pkg::DCD_CMD_RDA, dcd_pkg::DCD_CMD_PRE, dcd_pkg::DCD_CMD_PREA};
    for (int i = 0; i < 9; i++)
    begin
      @(posedge clk_in);
      bdrv(1'b1, pat[i], 3'h3);
      @(posedge clk_in);
      bdrv(1'b1, 5'h0e, 3'h3);
      @(negedge clk_in);
      chk(b_vld, 1'b1);
      chk(b_cmd, e[i]);
      repeat (5) @(posedge clk_in);
    end
  endtask
  task automatic t_illegal();
    @(posedge clk_in);
    bdrv(1'b0, 5'h06, 3'h1);
    @(posedge clk_in);
    bdrv(1'b0, 5'h0e, 3'h1);
    expect_ill();
    @(posedge clk_in);
    bdrv(1'b1, 5'h0e, 3'h3);
    repeat (8) @(posedge clk_in);
    bdrv(1'b1, 5'h06, 3'h3);
    repeat (3) @(posedge clk_in);
    bdrv(1'b1, 5'h0a, 3'h3);
    @(posedge clk_in);
    bdrv(1'b1, 5'h0a, 3'h3);
    @(posedge clk_in);
    bdrv(1'b1, 5'h0e, 3'h3);
    expect_ill();
  endtask
  task automatic t_write();
    @(posedge clk_in);
    odt_in <= 1'b1;
    req(dcd_pkg::DCD_CMD_ACT, 3'h5, 16'h0123, 4'hf);
    chk(bank_open_out, 16'h0020);
    chk(odt_on_out, 1'b1);
    beats.delete();
    req(dcd_pkg::DCD_CMD_WR, 3'h5, 16'h0040, 4'b0010);
    chk(got_bank, 3'h5);
    chk(got_addr, 16'h0040);
    chk(16'(beats.size()), 16'h0003);
    chk(beats[0], 8'h10);
    chk(beats[1], 8'h12);
    chk(beats[2], 8'h13);
  endtask
  task automatic t_read_mode();
    req(dcd_pkg::DCD_CMD_RDA, 3'h5, 16'h0400, 4'hf);
    chk(bank_open_out, 16'h0000);
    req(dcd_pkg::DCD_CMD_MRS, 3'h2, 16'h0a5c, 4'hf);
    chk(mrs_op_out, 16'h0a5c);
    chk(mrs_sel_out, 3'h2);
  endtask
  task automatic t_power_down();
    req(dcd_pkg::DCD_CMD_ACT, 3'h2, 16'h0007, 4'hf);
    @(posedge clk_in);
    pd_in <= 1'b1;
    wait_state(dcd_pkg::DCD_ST_APD);
    // The stay is kept short, far inside any refresh limit.
    repeat (20) @(negedge clk_in);
    chk(state_out, dcd_pkg::DCD_ST_APD);
    @(posedge clk_in);
    pd_in <= 1'b0;
    wait_state(dcd_pkg::DCD_ST_ACTIVE);
    req(dcd_pkg::DCD_CMD_PREA, 3'h0, 16'h0400, 4'hf);
    @(posedge clk_in);
    pd_in <= 1'b1;
    wait_state(dcd_pkg::DCD_ST_PPD);
    pd_in <= 1'b0;
    wait_state(dcd_pkg::DCD_ST_IDLE);
  endtask
  task automatic t_self_refresh();
    sref_in <= 1'b1;
    wait_state(dcd_pkg::DCD_ST_SREF);
    @(negedge clk_in);
    chk(odt_on_out, 1'b0);
    @(posedge clk_in);
    sref_in <= 1'b0;
    odt_in <= 1'b0;
    wait_state(dcd_pkg::DCD_ST_IDLE);
    req(dcd_pkg::DCD_CMD_ACT, 3'h1, 16'h0011, 4'hf);
    req(dcd_pkg::DCD_CMD_RD, 3'h1, 16'h0008, 4'hf);
  endtask
  // Main sequence: reset, lone-device cases, then the joined pair.
  initial
  begin
    bdrv(1'b0, 5'h0e, 3'h0);
    bad.odt <= 1'b0;
    bad.wdata <= 8'h00;
    bad.dm <= 1'b1;
    repeat (6) @(posedge clk_in);
    arst_n_in <= 1'b1;
    @(posedge clk_in);
    bdrv(1'b1, 5'h0e, 3'h0);
    repeat (4) @(posedge clk_in);
    t_decode_table();
    t_illegal();
    t_write();
    t_read_mode();
    t_power_down();
    t_self_refresh();
    finish_test();
  end
endmodule
`default_nettype wire
